// *** rtl/rebind_regs.vh ***
`ifndef REBIND_REGS_VH
`define REBIND_REGS_VH
// ==========================================================
// register offsets (byte addresses of the controller's own map)
`define RB_REG_CTRL 8'h00
`define RB_REG_SEL 8'h04
`define RB_REG_STATUS 8'h08
`define RB_REG_COUNT 8'h0C
`define RB_REG_ENTRY0 8'h10
// ==========================================================
// control bit positions
`define RB_CTRL_START 0
`define RB_CTRL_CLEAR 1
`define RB_CTRL_SLI 2
`define RB_CTRL_MULTI 3
// ==========================================================
// selector fields inside an entry word: port, type, index, channel id
`define RB_F_PORT_HI 31
`define RB_F_PORT_LO 24
`define RB_F_TYPE_HI 23
`define RB_F_TYPE_LO 16
`define RB_F_IDX_HI 15
`define RB_F_IDX_LO 8
`define RB_F_CHID_HI 7
`define RB_F_CHID_LO 0
// ==========================================================
// channel type codes
`define RB_CT_RESERVED 8'h00
`define RB_CT_DS_MULTI 8'h01
`define RB_CT_DS_LINKCTL 8'h02
`define RB_CT_DS_SINGLE 8'h03
`define RB_CT_US_BURST 8'h04
`define RB_CT_US_MULTI 8'h05
`define RB_CT_OOB1_FWD 8'h06
`define RB_CT_OOB1_RET 8'h07
`define RB_CT_OOB2_FWD 8'h08
`define RB_CT_OOB2_RET 8'h09
`define RB_CT_NB_FWD 8'h0A
`define RB_CT_NB_RET 8'h0B
`define RB_CT_SPECTRUM 8'h0C
`define RB_CT_PROBE 8'h0D
`define RB_CT_UNDEF15 8'h0F
`define RB_CT_RXMER 8'h0E
`define RB_CT_TIMING 8'h10
// ==========================================================
// pseudowire subtype codes (controller's own numbering)
`define RB_ST_PLAIN 4'h0
`define RB_ST_OOB2_FWD 4'h1
`define RB_ST_OOB2_RET 4'h2
`define RB_ST_SC_BWREQ 4'h3
`define RB_ST_ECHO 4'h4
`define RB_ST_ZBL 4'h5
`define RB_ST_SC_MAP 4'h6
`define RB_ST_SC_RNG 4'h7
`define RB_ST_MC_BWREQ 4'h8
`define RB_ST_MC_PROBE 4'h9
`define RB_ST_MC_RNG 4'hA
`define RB_ST_SPECMAN 4'hB
`define RB_ST_PLANT 4'hC
// ==========================================================
// attribute framing
`define RB_ATTR_TYPE 16'h0042
`define RB_ATTR_BASE_LEN 10'h008
`define RB_ENTRY_BYTES 10'h004
`endif

// *** rtl/rebind_codec.v ***
// How it works
// - first selector octet is an 8-bit port index, meaning set by type.
// - channel type is 8 bits; code zero reserved, never sent.
// - codes 1..5 are the downstream and upstream data channel kinds.
// - codes 6..11 are out-of-band and narrowband resources.
// - 12 spectrum, 13 probe, 14 error ratio, 16 timing; 15 undefined.
// - third selector octet is an 8-bit channel index within the type.
// - oob second forward, oob second return and spectrum types send index zero.
// - last octet is the channel id for multi-channel pseudowires.
// - single-channel pseudowires send channel id zero.
// - exactly one attribute is emitted per session request with a non-empty list.
// - multi-channel emits one entry per channel, no repeats; else one.
// - replicated entries may share channel id, one per destination.
// - five listed subtypes force channel index zero.
// - sc map and ranging subtypes copy the upstream sc channel selector.
// - mc request, probe and ranging copy the upstream mc channel selector.
// - spectrum management forces spectrum type, index zero; plant keeps spectrum with index zero, else copies base port and index.
// - value is two reserved octets then entries; length 8 + 4n.
// - selector is three octets: port, type, index in that order.
`timescale 1ns/100ps
`default_nettype none
`include "rebind_regs.vh"
module rebind_codec #(
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire arst_n,
   input wire clk_en,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata_ff,
   output wire msg_valid,
   input wire msg_ready,
   output reg [7:0] msg_byte_ff,
   output reg msg_first_ff,
   output reg msg_last_ff,
   output reg msg_sli_ff
);
   // ==========================================================
   // entry store and control registers
   reg [31:0] entry_mem [0:DEPTH-1];
   reg [AW:0] count_ff;
   reg [3:0] subtype_ff;
   reg multi_ff;
   reg sli_ff;
   reg [7:0] base_port_ff;
   reg [7:0] base_idx_ff;
   reg busy_ff;
   reg dup_err_ff;
   reg type_err_ff;
   reg empty_err_ff;
   reg sent_ff;

   localparam S_IDLE = 4'b0001;
   localparam S_HDR = 4'b0010;
   localparam S_BODY = 4'b0100;
   localparam S_DONE = 4'b1000;
   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [3:0] hdr_cnt_ff;
   reg [AW:0] ent_cnt_ff;
   reg [1:0] oct_cnt_ff;
   reg out_valid_ff;

   // legal code for the controller to emit
   function type_legal;
      input [7:0] t;
      begin
         type_legal = (t != `RB_CT_RESERVED) && (t <= `RB_CT_TIMING) &&
            (t != `RB_CT_UNDEF15);
      end
   endfunction

   // selector rewrite per subtype; the same decode shapes entry words
   // as they are stored on load and feeds the error checks on load
   function [31:0] shape;
      input [31:0] e;
      input [3:0] st;
      input multi;
      input [7:0] bport;
      input [7:0] bidx;
      reg [7:0] p;
      reg [7:0] t;
      reg [7:0] i;
      reg [7:0] c;
      begin
         p = e[`RB_F_PORT_HI:`RB_F_PORT_LO];
         t = e[`RB_F_TYPE_HI:`RB_F_TYPE_LO];
         i = e[`RB_F_IDX_HI:`RB_F_IDX_LO];
         c = e[`RB_F_CHID_HI:`RB_F_CHID_LO];
         case (st)
            `RB_ST_OOB2_FWD: begin
               t = `RB_CT_OOB2_FWD;
               i = 8'h00;
            end
            `RB_ST_OOB2_RET: begin
               t = `RB_CT_OOB2_RET;
               i = 8'h00;
            end
            `RB_ST_SC_BWREQ, `RB_ST_ECHO: begin
               if (st == `RB_ST_ECHO)
                  t = `RB_CT_US_MULTI;
               i = 8'h00;
            end
            `RB_ST_ZBL: begin
               t = `RB_CT_DS_MULTI;
               i = 8'h00;
            end
            `RB_ST_SC_MAP, `RB_ST_SC_RNG: begin
               p = bport;
               t = `RB_CT_US_BURST;
               i = bidx;
            end
            `RB_ST_MC_BWREQ, `RB_ST_MC_PROBE, `RB_ST_MC_RNG: begin
               p = bport;
               t = `RB_CT_US_MULTI;
               i = bidx;
            end
            `RB_ST_SPECMAN, `RB_ST_PLANT: begin
               if (st == `RB_ST_SPECMAN ||
                   t == `RB_CT_SPECTRUM) begin
                  t = `RB_CT_SPECTRUM;
                  i = 8'h00;
               end else begin
                  p = bport;
                  i = bidx;
               end
            end
            default: begin
               t = t;
            end
         endcase
         if (t == `RB_CT_OOB2_FWD || t == `RB_CT_OOB2_RET ||
             t == `RB_CT_SPECTRUM)
            i = 8'h00;
         if (!multi)
            c = 8'h00;
         shape = {p, t, i, c};
      end
   endfunction

   // ==========================================================
   // register port
   wire [31:0] ctrl_word;
   wire wr_ctrl;
   wire wr_entry;
   wire start_req;
   wire [AW:0] max_cnt;
   wire [31:0] shaped_w;
   reg dup_hit;
   integer k;

   assign wr_ctrl = reg_wr && reg_addr == `RB_REG_CTRL;
   assign wr_entry = reg_wr && reg_addr == `RB_REG_ENTRY0;
   assign start_req = wr_ctrl && reg_wdata[`RB_CTRL_START] && !busy_ff;
   assign max_cnt = DEPTH[AW:0];
   assign shaped_w = shape(reg_wdata, subtype_ff, multi_ff,
      base_port_ff, base_idx_ff);
   assign ctrl_word = {20'h00000, subtype_ff, 4'h0, multi_ff, sli_ff,
      1'b0, busy_ff};

   // a repeated selector in a multi-channel list would bind one channel
   // twice; replicated entries differ in selector so are not caught here
   always @* begin
      dup_hit = 1'b0;
      for (k = 0; k < DEPTH; k = k + 1) begin
         if (k < count_ff &&
             entry_mem[k][31:8] == shaped_w[31:8])
            dup_hit = 1'b1;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata_ff <= 32'h00000000;
         count_ff <= {(AW+1){1'b0}};
         subtype_ff <= 4'h0;
         multi_ff <= 1'b0;
         sli_ff <= 1'b0;
         base_port_ff <= 8'h00;
         base_idx_ff <= 8'h00;
         dup_err_ff <= 1'b0;
         type_err_ff <= 1'b0;
         empty_err_ff <= 1'b0;
      end else if (clk_en) begin
         reg_rdata_ff <= 32'h00000000;
         if (reg_rd) begin
            case (reg_addr)
               `RB_REG_CTRL: reg_rdata_ff <= ctrl_word;
               `RB_REG_SEL: reg_rdata_ff <= {16'h0000, base_port_ff,
                  base_idx_ff};
               `RB_REG_STATUS: reg_rdata_ff <= {28'h0000000, sent_ff,
                  empty_err_ff, type_err_ff, dup_err_ff};
               `RB_REG_COUNT: reg_rdata_ff <= {{(31-AW){1'b0}}, count_ff};
               default: reg_rdata_ff <= 32'h00000000;
            endcase
         end
         if (wr_ctrl && !busy_ff) begin
            subtype_ff <= reg_wdata[11:8];
            multi_ff <= reg_wdata[`RB_CTRL_MULTI];
            sli_ff <= reg_wdata[`RB_CTRL_SLI];
            if (reg_wdata[`RB_CTRL_CLEAR]) begin
               count_ff <= {(AW+1){1'b0}};
               dup_err_ff <= 1'b0;
               type_err_ff <= 1'b0;
               empty_err_ff <= 1'b0;
            end
            if (reg_wdata[`RB_CTRL_START] && count_ff == 0)
               empty_err_ff <= 1'b1;
         end
         if (reg_wr && reg_addr == `RB_REG_SEL && !busy_ff) begin
            base_port_ff <= reg_wdata[15:8];
            base_idx_ff <= reg_wdata[7:0];
         end
         // a single-channel session keeps only one entry: later writes
         // overwrite it rather than growing the list
         if (wr_entry && !busy_ff) begin
            if (!type_legal(shaped_w[`RB_F_TYPE_HI:`RB_F_TYPE_LO]))
               type_err_ff <= 1'b1;
            else if (multi_ff && dup_hit)
               dup_err_ff <= 1'b1;
            else if (!multi_ff)
               count_ff <= {{AW{1'b0}}, 1'b1};
            else if (count_ff != max_cnt)
               count_ff <= count_ff + 1'b1;
         end
      end
   end

   always @(posedge clk) begin
      if (clk_en && wr_entry && !busy_ff &&
          type_legal(shaped_w[`RB_F_TYPE_HI:`RB_F_TYPE_LO])) begin
         if (!multi_ff)
            entry_mem[0] <= shaped_w;
         else if (!dup_hit && count_ff != max_cnt)
            entry_mem[count_ff[AW-1:0]] <= shaped_w;
      end
   end

   // ==========================================================
   // attribute emission: 8 header octets then 4 per entry
   wire [9:0] attr_len;
   wire [15:0] attr_type_w;
   wire adv;
   wire [31:0] cur_ent;
   reg [7:0] hdr_byte;
   assign attr_len = `RB_ATTR_BASE_LEN +
      {count_ff[AW:0], 2'b00};
   assign attr_type_w = `RB_ATTR_TYPE;
   assign msg_valid = out_valid_ff;
   assign adv = !out_valid_ff || msg_ready;
   assign cur_ent = entry_mem[ent_cnt_ff[AW-1:0]];

   always @* begin
      case (hdr_cnt_ff)
         4'h0: hdr_byte = {6'h00, attr_len[9:8]};
         4'h1: hdr_byte = attr_len[7:0];
         4'h2: hdr_byte = 8'h00;
         4'h3: hdr_byte = 8'h00;
         4'h4: hdr_byte = attr_type_w[15:8];
         4'h5: hdr_byte = attr_type_w[7:0];
         default: hdr_byte = 8'h00;
      endcase
   end

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: if (start_req && count_ff != 0) nxt_state = S_HDR;
         S_HDR: if (adv && hdr_cnt_ff == 4'h7) nxt_state = S_BODY;
         S_BODY: if (adv && oct_cnt_ff == 2'h3 &&
            ent_cnt_ff == count_ff - 1'b1) nxt_state = S_DONE;
         S_DONE: if (adv) nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end

   // one attribute per start with a non-empty list; the list is not cleared so the same list
   // can be resent in a link-info message to replace the remote copy
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= S_IDLE;
         hdr_cnt_ff <= 4'h0;
         ent_cnt_ff <= {(AW+1){1'b0}};
         oct_cnt_ff <= 2'h0;
         out_valid_ff <= 1'b0;
         msg_byte_ff <= 8'h00;
         msg_first_ff <= 1'b0;
         msg_last_ff <= 1'b0;
         msg_sli_ff <= 1'b0;
         busy_ff <= 1'b0;
         sent_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         if (start_req && count_ff != 0) begin
            busy_ff <= 1'b1;
            sent_ff <= 1'b0;
            msg_sli_ff <= sli_ff;
            hdr_cnt_ff <= 4'h0;
            ent_cnt_ff <= {(AW+1){1'b0}};
            oct_cnt_ff <= 2'h0;
         end
         if (adv) begin
            out_valid_ff <= 1'b0;
            msg_first_ff <= 1'b0;
            msg_last_ff <= 1'b0;
            case (state_ff)
               S_HDR: begin
                  out_valid_ff <= 1'b1;
                  msg_byte_ff <= hdr_byte;
                  msg_first_ff <= hdr_cnt_ff == 4'h0;
                  hdr_cnt_ff <= hdr_cnt_ff + 4'h1;
               end
               S_BODY: begin
                  out_valid_ff <= 1'b1;
                  msg_byte_ff <= cur_ent[{~oct_cnt_ff, 3'b000} +: 8];
                  msg_last_ff <= oct_cnt_ff == 2'h3 &&
                     ent_cnt_ff == count_ff - 1'b1;
                  oct_cnt_ff <= oct_cnt_ff + 2'h1;
                  if (oct_cnt_ff == 2'h3)
                     ent_cnt_ff <= ent_cnt_ff + 1'b1;
               end
               S_DONE: begin
                  busy_ff <= 1'b0;
                  sent_ff <= 1'b1;
               end
               default: begin
                  out_valid_ff <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/recbc_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module recbc_asserts (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic msg_valid,
   input wire logic msg_ready,
   input wire logic [7:0] msg_byte_ff,
   input wire logic msg_first_ff,
   input wire logic msg_last_ff,
   input wire logic msg_sli_ff
);
   // ==========================================================
   // octet position, so header and entry fields can be told apart
   logic fire;
   logic [6:0] pos_ff;
   logic [7:0] len_ff;
   assign fire = msg_valid && msg_ready && clk_en;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_ff <= 7'h00;
         len_ff <= 8'h00;
      end else if (fire) begin
         pos_ff <= msg_last_ff ? 7'h00 : pos_ff + 7'h01;
         if (pos_ff == 7'h01) len_ff <= msg_byte_ff;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ==========================================================
   // framing and field checks
   a_first_pos: assert property (msg_valid && msg_first_ff |->
      pos_ff == 7'h00 && msg_byte_ff == 8'h00) else $error("bad first octet");
   a_len_match: assert property (fire && msg_last_ff |->
      len_ff == {1'b0, pos_ff} + 8'h01) else $error("length mismatch");
   a_hdr_zero: assert property (msg_valid && pos_ff inside
      {7'h02, 7'h03, 7'h04, 7'h06, 7'h07} |-> msg_byte_ff == 8'h00)
      else $error("header octet not zero");
   a_attr_code: assert property (msg_valid && pos_ff == 7'h05 |->
      msg_byte_ff == 8'h42) else $error("wrong attribute code");
   a_type_legal: assert property (msg_valid && pos_ff > 7'h08 &&
      pos_ff[1:0] == 2'b01 |-> msg_byte_ff inside {[8'h01:8'h0E], 8'h10})
      else $error("illegal channel type sent");
   a_octet_hold: assert property (msg_valid && !msg_ready && clk_en
      |=> msg_valid && $stable(msg_byte_ff) && $stable(msg_last_ff))
      else $error("octet changed while stalled");
   a_frame_gap: assert property (fire && msg_last_ff |=>
      !msg_valid [*2]) else $error("octets after last");
   a_sli_frame: assert property (msg_valid && $past(msg_valid) |->
      $stable(msg_sli_ff)) else $error("replace flag moved in frame");
   c_stall: cover property (msg_valid && !msg_ready);
   c_sli: cover property (fire && msg_last_ff && msg_sli_ff);
   c_long: cover property (fire && pos_ff == 7'h43);
endmodule
bind rebind_codec recbc_asserts recbc_asserts_inst (.clk(clk),
   .arst_n(arst_n), .clk_en(clk_en), .msg_valid(msg_valid),
   .msg_ready(msg_ready), .msg_byte_ff(msg_byte_ff),
   .msg_first_ff(msg_first_ff), .msg_last_ff(msg_last_ff),
   .msg_sli_ff(msg_sli_ff));
`default_nettype wire

// *** sim/recbc_remote_node.sv ***
`timescale 1ns/100ps
`default_nettype none
module recbc_remote_node (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic msg_valid,
   input wire logic [7:0] msg_byte_ff,
   input wire logic msg_first_ff,
   input wire logic msg_last_ff,
   output logic msg_ready,
   output logic [31:0] rx_list [0:15],
   output int rx_count,
   output logic rx_bad,
   output int rx_frames
);
   logic [7:0] octet [0:71];
   logic [31:0] bound [0:15];
   logic [31:0] e;
   logic [1:0] ph;
   logic bad;
   int pos;
   int n;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos = 0;
         ph = 2'b00;
         msg_ready <= 1'b0;
         rx_count <= 0;
         rx_bad <= 1'b0;
         rx_frames <= 0;
      end else begin
         ph = ph + 2'b01;
         // slow mode accepts only half the time, to stall the sender
         msg_ready <= !slow || ph[1];
         if (msg_valid && msg_ready) begin
            if (msg_first_ff) pos = 0;
            if (pos < 72) octet[pos] = msg_byte_ff;
            pos = pos + 1;
            if (msg_last_ff) begin
               n = (pos - 8) / 4;
               bad = pos % 4 != 0 || {octet[0], octet[1]} != pos;
               for (int i = 0; i < 16; i++) begin
                  e = (i < n) ? {octet[4*i+8], octet[4*i+9],
                     octet[4*i+10], octet[4*i+11]} : 32'h0;
                  if (i < n && !(e[23:16] inside {[8'h01:8'h0E], 8'h10}))
                     bad = 1'b1;
                  // port names a module or circuit, index is not bound
                  bound[i] = (e[23:16] inside {8'h08, 8'h09, 8'h0C}) ?
                     {e[31:16], 8'h00, e[7:0]} : e;
                  // a selector the core should have zeroed is malformed
                  if (bound[i] != e) bad = 1'b1;
                  rx_list[i] <= e;
               end
               rx_count <= n;
               rx_bad <= bad;
               rx_frames <= rx_frames + 1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/remote_end_channel_binding_codec_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "rebind_regs.vh"
module remote_end_channel_binding_codec_tb;
   logic clk, arst_n, clk_en, reg_wr, reg_rd, slow, rx_bad;
   logic msg_valid, msg_ready, msg_first_ff, msg_last_ff, msg_sli_ff;
   logic [7:0] reg_addr, msg_byte_ff, t;
   logic [31:0] reg_wdata, reg_rdata_ff, d;
   logic [31:0] rx_list [0:15];
   int rx_count, rx_frames, checks, n_mismatch;
   // subtypes 1..12: entry written, then entry expected on the wire
   logic [31:0] st_in [0:11] = '{32'h01080733, 32'h01090733,
      32'h01040733, 32'h01040733, 32'h01030733, 32'h09040933,
      32'h09040933, 32'h09050933, 32'h09050933, 32'h09050933,
      32'h030C0933, 32'h030C0933};
   logic [31:0] st_out [0:11] = '{32'h01080000, 32'h01090000,
      32'h01040000, 32'h01050000, 32'h01010000, 32'h02040600,
      32'h02040600, 32'h02050600, 32'h02050600, 32'h02050600,
      32'h030C0000, 32'h030C0000};
   logic [31:0] rep [0:3] = '{32'h00030005, 32'h00030105,
      32'h01030005, 32'h01030007};
   rebind_codec rebind_codec_inst (.clk(clk), .arst_n(arst_n),
      .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
      .msg_valid(msg_valid), .msg_ready(msg_ready),
      .msg_byte_ff(msg_byte_ff), .msg_first_ff(msg_first_ff),
      .msg_last_ff(msg_last_ff), .msg_sli_ff(msg_sli_ff));
   recbc_remote_node recbc_remote_node_inst (.clk(clk), .arst_n(arst_n),
      .slow(slow), .msg_valid(msg_valid), .msg_byte_ff(msg_byte_ff),
      .msg_first_ff(msg_first_ff), .msg_last_ff(msg_last_ff),
      .msg_ready(msg_ready), .rx_list(rx_list), .rx_count(rx_count),
      .rx_bad(rx_bad), .rx_frames(rx_frames));
   // ==========================================================
   // helpers
   function automatic logic [31:0] cfg(input logic [3:0] st,
      input logic m, input logic s);
      return {20'h0, st, 4'h0, m, s, 2'b00};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // strobe drops one edge before the next access may raise it
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      r = reg_rdata_ff;
   endtask
   task automatic go(input logic [31:0] c, input int nfr);
      logic [31:0] s;
      int f;
      int k;
      f = rx_frames;
      k = 0;
      wr(`RB_REG_CTRL, c | 32'h1);
      do begin
         rd(`RB_REG_CTRL, s);
         k++;
      end while (s[0] !== 1'b0 && k < 300);
      check(rx_frames, f + nfr);
      check({31'h0, rx_bad}, 32'h0);
      check({31'h0, msg_sli_ff}, {31'h0, c[2]});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // clock, watchdog, tests
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      slow = 1'b0;
      checks = 0;
      n_mismatch = 0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      slow <= 1'b1;
      wr(`RB_REG_CTRL, cfg(4'h0, 1'b1, 1'b0) | 32'h2);
      rd(`RB_REG_CTRL, d);
      check(d & 32'h00000F0D, cfg(4'h0, 1'b1, 1'b0));
      for (int i = 0; i < 15; i++) begin
         t = (i < 14) ? 8'(i + 1) : 8'h10;
         wr(`RB_REG_ENTRY0, {8'h01, t, i[7:0], i[7:0]});
      end
      go(cfg(4'h0, 1'b1, 1'b0), 1);
      rd(`RB_REG_COUNT, d);
      check(d, 32'h0000000F);
      for (int i = 0; i < 15; i++) begin
         t = (i < 14) ? 8'(i + 1) : 8'h10;
         d = {8'h01, t, i[7:0], i[7:0]};
         if (t inside {8'h08, 8'h09, 8'h0C}) d[15:8] = 8'h00;
         check(rx_list[i], d);
      end
      slow <= 1'b0;
      wr(`RB_REG_CTRL, cfg(4'h0, 1'b1, 1'b0) | 32'h2);
      for (int i = 0; i < 4; i++) wr(`RB_REG_ENTRY0, rep[i]);
      go(cfg(4'h0, 1'b1, 1'b0), 1);
      rd(`RB_REG_STATUS, d);
      check(d & 32'h1, 32'h1);
      check(d & 32'h8, 32'h8);
      check(rx_count, 32'h3);
      for (int i = 0; i < 3; i++) check(rx_list[i], rep[i]);
      wr(`RB_REG_CTRL, cfg(4'h0, 1'b0, 1'b1) | 32'h2);
      wr(`RB_REG_ENTRY0, 32'h02030400);
      go(cfg(4'h0, 1'b0, 1'b1), 1);
      check(rx_count, 32'h1);
      check(rx_list[1], 32'h0);
      wr(`RB_REG_SEL, 32'h00000206);
      rd(`RB_REG_SEL, d);
      check(d & 32'h0000FFFF, 32'h00000206);
      clk_en <= 1'b0;
      wr(`RB_REG_SEL, 32'h0000FFFF);
      clk_en <= 1'b1;
      rd(`RB_REG_SEL, d);
      check(d & 32'h0000FFFF, 32'h00000206);
      for (int s = 1; s <= 12; s++) begin
         wr(`RB_REG_CTRL, cfg(s[3:0], 1'b0, 1'b0) | 32'h2);
         wr(`RB_REG_ENTRY0, 32'h55010203);
         wr(`RB_REG_ENTRY0, st_in[s-1]);
         go(cfg(s[3:0], 1'b0, 1'b0), 1);
         check(rx_count, 32'h1);
         check(rx_list[0], st_out[s-1]);
      end
      wr(`RB_REG_CTRL, cfg(4'hC, 1'b0, 1'b0) | 32'h2);
      wr(`RB_REG_ENTRY0, 32'h010D0933);
      go(cfg(4'hC, 1'b0, 1'b0), 1);
      check(rx_list[0], 32'h020D0600);
      wr(`RB_REG_CTRL, cfg(4'h0, 1'b1, 1'b0) | 32'h2);
      wr(`RB_REG_ENTRY0, 32'h01000000);
      wr(`RB_REG_ENTRY0, 32'h010F0100);
      wr(`RB_REG_ENTRY0, 32'h01110200);
      go(cfg(4'h0, 1'b1, 1'b0), 0);
      rd(`RB_REG_COUNT, d);
      check(d, 32'h0);
      rd(`RB_REG_STATUS, d);
      check(d & 32'h6, 32'h6);
      rd(8'h40, d);
      check(d, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
